// *** hw/tbes_pkg.sv ***
// Package for the Type B transmitter edge shaping configuration block.
// Assumes one 100 MHz clock and an 8-bit register port with byte registers.
package tbes_pkg;

  // ---------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CFG = 4;

  // Register indices; the byte address on the port is four times the index.
  localparam logic [7:0] IDX_EDGE_STYLE = 8'h26;
  localparam logic [7:0] IDX_EDGE_LENGTH = 8'h27;
  localparam logic [7:0] IDX_RESIDUAL = 8'h28;
  localparam logic [7:0] IDX_EDGE_TYPE = 8'h29;
  localparam logic [7:0] IDX_STATUS = 8'h30;

  localparam logic [NUM_CFG-1:0][7:0] CFG_IDX =
    {IDX_EDGE_TYPE, IDX_RESIDUAL, IDX_EDGE_LENGTH, IDX_EDGE_STYLE};

  // Reset values of the configuration bytes.
  localparam logic [7:0] RST_EDGE_STYLE = 8'h00;
  localparam logic [7:0] RST_EDGE_LENGTH = 8'h00;
  localparam logic [7:0] RST_RESIDUAL = 8'h00;
  localparam logic [7:0] RST_EDGE_TYPE = 8'h00;
  localparam logic [NUM_CFG-1:0][7:0] CFG_RESET =
    {RST_EDGE_TYPE, RST_RESIDUAL, RST_EDGE_LENGTH, RST_EDGE_STYLE};

  // Writable bits; reserved bits are dropped and read back as zero.
  localparam logic [NUM_CFG-1:0][7:0] CFG_WMASK =
    {8'hff, 8'hff, 8'h9f, 8'h77};

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int FALL_STYLE_LSB = 4;
  localparam int RISE_STYLE_LSB = 0;
  localparam int SCALE_BIT = 7;
  localparam int COUNT_LSB = 0;
  localparam int FALL_TYPE_LSB = 4;
  localparam int RISE_TYPE_LSB = 0;
  localparam int ST_RESERVED_BIT = 6;
  localparam int ST_AT_RES_BIT = 5;
  localparam int ST_ACTIVE_BIT = 7;

  // ---------------------------------------------------------------------
  // Edge type codes and levels
  // ---------------------------------------------------------------------
  localparam logic [3:0] TYPE_LIN1 = 4'h1;
  localparam logic [3:0] TYPE_LIN2 = 4'h2;
  localparam logic [3:0] TYPE_LIN3 = 4'h3;
  localparam logic [3:0] TYPE_LUT = 4'h4;
  localparam logic [3:0] TYPE_LUT_ADAPT_CORR = 4'h5;
  localparam logic [3:0] TYPE_LUT_ADAPT = 4'h6;

  localparam logic [7:0] FULL_AMP = 8'hff;
  localparam logic [7:0] SUPPLY_NOM = 8'h80;
  localparam logic [8:0] PROG_FULL = 9'h100;

  // Four lookup tables of eight points each, fraction of the swing in 1/256.
  localparam logic [3:0][7:0][8:0] TBES_LUT = {
    {9'h100, 9'h0f8, 9'h0e8, 9'h0c8, 9'h098, 9'h060, 9'h030, 9'h010},
    {9'h100, 9'h0f0, 9'h0d0, 9'h0a0, 9'h070, 9'h040, 9'h020, 9'h008},
    {9'h100, 9'h0e0, 9'h0c0, 9'h0a0, 9'h080, 9'h060, 9'h040, 9'h020},
    {9'h100, 9'h0fc, 9'h0f0, 9'h0d8, 9'h0b0, 9'h080, 9'h048, 9'h018}};

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FALL = 3'b010,
    ST_RISE = 3'b100
  } tbes_state_t;

  typedef struct packed {
    logic [7:0] edge_type;
    logic [7:0] residual;
    logic [7:0] edge_length;
    logic [7:0] edge_style;
  } tbes_cfg_t;

  typedef struct packed {
    logic [3:0] edge_type;
    logic [2:0] edge_style;
    logic [8:0] progress;
  } tbes_shape_t;

endpackage : tbes_pkg

// *** hw/tbes_profile.sv ***
// Turns edge progress into a fraction of the amplitude swing.
// Assumes progress runs 0 to 256 over the active transition states.
`timescale 1ns/1ps
`default_nettype none
module tbes_profile
  import tbes_pkg::*;
(
  // Shape request
  input  wire tbes_shape_t shape,
  // Fraction of the swing, 0 to 256
  output logic [8:0]       fraction
);

  logic [8:0] p;
  logic [8:0] knee2;
  logic [8:0] knee3;
  logic [17:0] prod;

  assign p = shape.progress;
  assign knee2 = 9'(9'h040 + {2'b00, shape.edge_style, 4'h0});
  assign knee3 = {3'b000, shape.edge_style, 3'b000};

  always_comb begin
    prod = 18'h00000;
    case (shape.edge_type)
      TYPE_LIN1: begin
        fraction = p;
      end
      TYPE_LIN2: begin
        if (p < 9'h080) begin
          prod = 18'(p * knee2);
          fraction = 9'(prod >> 7);
        end else begin
          prod = 18'((p - 9'h080) * (PROG_FULL - knee2));
          fraction = 9'(knee2 + 9'(prod >> 7));
        end
      end
      TYPE_LIN3: begin
        if (p < 9'h040) begin
          prod = 18'(p * knee3);
          fraction = 9'(prod >> 6);
        end else if (p < 9'h0c0) begin
          prod = 18'((p - 9'h040) * (PROG_FULL - 9'(knee3 << 1)));
          fraction = 9'(knee3 + 9'(prod >> 7));
        end else begin
          prod = 18'((p - 9'h0c0) * knee3);
          fraction = 9'(PROG_FULL - knee3 + 9'(prod >> 6));
        end
      end
      TYPE_LUT, TYPE_LUT_ADAPT_CORR, TYPE_LUT_ADAPT: begin
        // Four tables only; the top style bit has no table behind it.
        if (p[8]) begin
          fraction = PROG_FULL;
        end else begin
          fraction = TBES_LUT[shape.edge_style[1:0]][p[7:5]];
        end
      end
      default: begin
        // Reserved codes give no transition: the target level is taken.
        fraction = PROG_FULL;
      end
    endcase
  end

endmodule : tbes_profile
`default_nettype wire

// *** hw/tbes_adapt.sv ***
// Maps a swing fraction onto the carrier amplitude, with supply adaptation.
// Assumes the supply code reads SUPPLY_NOM at nominal transmitter supply.
`timescale 1ns/1ps
`default_nettype none
module tbes_adapt
  import tbes_pkg::*;
(
  // Shaping inputs
  input  wire logic [3:0] edge_type,
  input  wire logic [8:0] fraction,
  input  wire logic [7:0] supply,
  input  wire logic [7:0] residual,
  input  wire logic       falling,
  // Amplitude
  output logic [7:0]      amp
);

  logic [16:0] scaled;
  logic [8:0]  frac_adj;
  logic [9:0]  low_calc;
  logic [7:0]  low;
  logic [7:0]  span;
  logic [16:0] step;

  always_comb begin
    scaled = 17'(fraction * supply) >> 7;
    frac_adj = fraction;
    low_calc = {2'b00, residual};
    if (edge_type == TYPE_LUT_ADAPT || edge_type == TYPE_LUT_ADAPT_CORR) begin
      // A higher supply scales the fraction up, so the table runs faster.
      frac_adj = (scaled > 17'(PROG_FULL)) ? PROG_FULL : 9'(scaled);
    end
    if (edge_type == TYPE_LUT_ADAPT_CORR) begin
      // The residual level drifts with supply; half the error is put back.
      low_calc = 10'({2'b00, residual} + 10'({2'b00, SUPPLY_NOM} >> 1)
                 - 10'({2'b00, supply} >> 1));
    end
    if (low_calc[9]) begin
      low = 8'h00;
    end else if (low_calc[8]) begin
      low = FULL_AMP;
    end else begin
      low = low_calc[7:0];
    end
    span = FULL_AMP - low;
    step = 17'(span * frac_adj) >> 8;
    // Residual code maps linearly: 0 is no carrier, all ones is full carrier.
    if (falling) begin
      amp = FULL_AMP - step[7:0];
    end else begin
      amp = low + step[7:0];
    end
  end

endmodule : tbes_adapt
`default_nettype wire

// *** hw/tbes_top.sv ***
// Type B transmitter edge shaping: configuration bytes and edge sequencer.
// Assumes CARRIER_TICK, MOD_REQ and SUPPLY_LEVEL come from MCLK logic.
//
// Notes on behaviour
// - Falling style field: time constant for codes 1-3, table number for 4-6.
// - Rising style field: time constant for codes 1-3, table number for 4-6.
// - Scaling bit clear: each transition state lasts one carrier cycle.
// - Scaling bit set: each transition state lasts two carrier cycles.
// - Five-bit count gives active transition states, same for both edges.
// - Residual amplitude maps linearly, zero none, all ones full carrier.
// - Upper nibble of edge type selects falling edge style.
// - Lower nibble of edge type selects rising edge style.
// - Code 1: one linear ramp between the two levels.
// - Code 2: two successive linear ramps through an intermediate level.
// - Code 3: three successive linear ramps; codes 0 and 7-15 reserved.
// - Code 4: lookup table shaping without supply adaptation.
// - Code 5: lookup table shaping, supply adapted, with correction.
// - Code 6: lookup table shaping, supply adapted, no correction.
`timescale 1ns/1ps
`default_nettype none
module tbes_top
  import tbes_pkg::*;
(
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST_B,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic      [DATA_W-1:0] RDATA,
  // Transmitter side
  input  wire logic              CARRIER_TICK,
  input  wire logic              MOD_REQ,
  input  wire logic [7:0]        SUPPLY_LEVEL,
  output logic      [7:0]        AMPLITUDE,
  output logic                   EDGE_ACTIVE,
  output logic                   AT_RESIDUAL
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic [NUM_CFG-1:0][7:0] cfg_reg;
  logic [NUM_CFG-1:0]      cfg_hit;
  tbes_cfg_t               live_cfg;
  tbes_cfg_t               act_cfg;
  tbes_state_t             state;
  tbes_state_t             next_state;
  logic [4:0]              step_k;
  logic [4:0]              next_step_k;
  logic [4:0]              edge_count;
  logic                    hold;
  logic                    next_hold;
  logic                    at_residual;
  logic                    next_at_residual;
  logic                    edge_active;
  logic                    reserved_seen;
  logic                    status_hit;
  logic                    falling;
  logic [3:0]              sel_type;
  logic [2:0]              sel_style;
  logic [12:0]             prog_wide;
  logic [8:0]              progress;
  tbes_shape_t             shape;
  logic [8:0]              fraction;
  logic [7:0]              shaped_amp;
  logic [7:0]              amp;
  logic [7:0]              status_byte;
  logic [DATA_W-1:0]       rdata;
  logic                    type_reserved;
  logic                    scale_en;
  logic [4:0]              cfg_count;

  // ---------------------------------------------------------------------
  // Register decode and storage
  // ---------------------------------------------------------------------
  assign status_hit = (ADDR == {IDX_STATUS[5:0], 2'b00});

  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g = g + 1) begin : g_cfg
      assign cfg_hit[g] = (ADDR == {CFG_IDX[g][5:0], 2'b00});

      always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
          cfg_reg[g] <= CFG_RESET[g];
        end else if (WR_STB && cfg_hit[g]) begin
          cfg_reg[g] <= WDATA & CFG_WMASK[g];
        end
      end
    end
  endgenerate

  assign live_cfg = tbes_cfg_t'(cfg_reg);

  // The shaping logic picks up new settings only on a carrier tick, so a
  // write never lands in the middle of a carrier cycle.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      act_cfg <= tbes_cfg_t'(CFG_RESET);
    end else if (CARRIER_TICK) begin
      act_cfg <= live_cfg;
    end
  end

  assign scale_en = act_cfg.edge_length[SCALE_BIT];
  assign cfg_count = act_cfg.edge_length[COUNT_LSB +: 5];

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  assign status_byte = {edge_active, reserved_seen, at_residual, step_k};

  always_comb begin
    rdata = 8'h00;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (cfg_hit[i]) begin
        rdata = cfg_reg[i];
      end
    end
    if (status_hit) begin
      rdata = status_byte;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (RD_STB) begin
      RDATA <= rdata;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------
  // Edge selection
  // ---------------------------------------------------------------------
  // In idle the direction follows the level already reached, so the same
  // path computes the resting amplitude with full progress.
  assign falling = (state == ST_FALL) || (state == ST_IDLE && at_residual);

  always_comb begin
    if (falling) begin
      sel_type = act_cfg.edge_type[FALL_TYPE_LSB +: 4];
      sel_style = act_cfg.edge_style[FALL_STYLE_LSB +: 3];
    end else begin
      sel_type = act_cfg.edge_type[RISE_TYPE_LSB +: 4];
      sel_style = act_cfg.edge_style[RISE_STYLE_LSB +: 3];
    end
  end

  assign type_reserved = (sel_type == 4'h0) || (sel_type > TYPE_LUT_ADAPT);

  // Progress through the edge in 1/256 of its transition states. The divider is
  // combinational; the count is at most 31, which keeps it small.
  always_comb begin
    prog_wide = 13'h0000;
    if (state == ST_IDLE || edge_count == 5'h00) begin
      progress = PROG_FULL;
    end else begin
      prog_wide = 13'({step_k, 8'h00} / {8'h00, edge_count});
      progress = prog_wide[8:0];
    end
  end

  assign shape.edge_type = sel_type;
  assign shape.edge_style = sel_style;
  assign shape.progress = progress;

  tbes_profile u_profile (
    .shape    (shape),
    .fraction (fraction)
  );

  tbes_adapt u_adapt (
    .edge_type (sel_type),
    .fraction  (fraction),
    .supply    (SUPPLY_LEVEL),
    .residual  (act_cfg.residual),
    .falling   (falling),
    .amp       (shaped_amp)
  );

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_step_k = step_k;
    next_hold = hold;
    next_at_residual = at_residual;
    case (state)
      ST_IDLE: begin
        if (MOD_REQ != at_residual) begin
          if (cfg_count == 5'h00) begin
            // No transition states: the new level is taken at once.
            next_at_residual = MOD_REQ;
          end else begin
            next_state = MOD_REQ ? ST_FALL : ST_RISE;
            next_step_k = 5'h01;
            next_hold = 1'b0;
          end
        end
      end
      ST_FALL, ST_RISE: begin
        if (scale_en && !hold) begin
          next_hold = 1'b1;
        end else begin
          next_hold = 1'b0;
          if (step_k >= edge_count) begin
            next_state = ST_IDLE;
            next_at_residual = (state == ST_FALL);
          end else begin
            next_step_k = step_k + 5'h01;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      step_k <= 5'h00;
      hold <= 1'b0;
      at_residual <= 1'b0;
    end else if (CARRIER_TICK) begin
      state <= next_state;
      step_k <= next_step_k;
      hold <= next_hold;
      at_residual <= next_at_residual;
    end
  end

  // The count is frozen for the length of an edge; a change mid-edge would
  // otherwise let the step run past the end.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      edge_count <= 5'h00;
    end else if (CARRIER_TICK && state == ST_IDLE) begin
      edge_count <= cfg_count;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      edge_active <= 1'b0;
    end else if (CARRIER_TICK) begin
      edge_active <= (next_state != ST_IDLE);
    end
  end

  // ---------------------------------------------------------------------
  // Reserved style flag
  // ---------------------------------------------------------------------
  // Sticky; writing one to its status bit clears it, but a new sighting in
  // the same cycle wins over the clear.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      reserved_seen <= 1'b0;
    end else if (CARRIER_TICK && state != ST_IDLE && type_reserved) begin
      reserved_seen <= 1'b1;
    end else if (WR_STB && status_hit && WDATA[ST_RESERVED_BIT]) begin
      reserved_seen <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      amp <= FULL_AMP;
    end else if (CARRIER_TICK) begin
      amp <= shaped_amp;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      AMPLITUDE <= FULL_AMP;
      EDGE_ACTIVE <= 1'b0;
      AT_RESIDUAL <= 1'b0;
    end else begin
      AMPLITUDE <= amp;
      EDGE_ACTIVE <= edge_active;
      AT_RESIDUAL <= at_residual;
    end
  end

endmodule : tbes_top
`default_nettype wire

// *** dv/tbes_assertions.sv ***
// Checker for the edge shaping block, watching only the ports of its top.
// Assumes the single MCLK domain and the active low reset RST_B.
`timescale 1ns/1ps
`default_nettype none
module tbes_assertions
  import tbes_pkg::*;
(
  // Clock and reset
  input wire logic              MCLK,
  input wire logic              RST_B,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR_STB,
  input wire logic              RD_STB,
  input wire logic [DATA_W-1:0] RDATA,
  // Transmitter side
  input wire logic              CARRIER_TICK,
  input wire logic              MOD_REQ,
  input wire logic [7:0]        SUPPLY_LEVEL,
  input wire logic [7:0]        AMPLITUDE,
  input wire logic              EDGE_ACTIVE,
  input wire logic              AT_RESIDUAL
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // -----------------------------------------------------------------
  // Sequences
  // -----------------------------------------------------------------
  sequence s_rd_style;
    RD_STB && ADDR == 8'h98;
  endsequence
  sequence s_rd_length;
    RD_STB && ADDR == 8'h9c;
  endsequence
  sequence s_rd_unmapped;
    RD_STB && !(ADDR inside {8'h98, 8'h9c, 8'ha0, 8'ha4, 8'hc0});
  endsequence
  // The outputs lag the sequencer by one MCLK, so the tick is two back; one back is also accepted.
  sequence s_tick_before;
    $past(CARRIER_TICK, 1) || $past(CARRIER_TICK, 2);
  endsequence

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  a_style_rsv_zero: assert property (
    s_rd_style |=> RDATA[7] == 1'b0 && RDATA[3] == 1'b0)
    else $error("reserved style bits read nonzero");
  a_length_rsv_zero: assert property (
    s_rd_length |=> RDATA[6:5] == 2'h0)
    else $error("reserved length bits read nonzero");
  a_unmapped_reads_zero: assert property (
    s_rd_unmapped |=> RDATA == 8'h00)
    else $error("unmapped read returned data");
  a_fall_monotone: assert property (
    MOD_REQ && $past(MOD_REQ) |-> AMPLITUDE <= $past(AMPLITUDE))
    else $error("amplitude rose while modulating");
  a_rise_monotone: assert property (
    !MOD_REQ && !$past(MOD_REQ) |-> AMPLITUDE >= $past(AMPLITUDE))
    else $error("amplitude fell while not modulating");
  a_edge_on_tick: assert property (
    $rose(EDGE_ACTIVE) |-> s_tick_before)
    else $error("edge started without a carrier tick");
  a_amp_on_tick: assert property (
    $changed(AMPLITUDE) |-> s_tick_before)
    else $error("amplitude moved without a carrier tick");
  a_res_after_fall: assert property (
    $fell(EDGE_ACTIVE) && MOD_REQ |-> ##[0:1] AT_RESIDUAL)
    else $error("falling edge ended off residual");
  a_full_after_rise: assert property (
    $fell(EDGE_ACTIVE) && !MOD_REQ |-> ##[0:1] !AT_RESIDUAL)
    else $error("rising edge ended at residual");
  a_rdata_idle_zero: assert property (
    !RD_STB |=> RDATA == 8'h00)
    else $error("read data seen without a read strobe");
endmodule : tbes_assertions

bind tbes_top tbes_assertions i_tbes_assertions (
  .MCLK, .RST_B, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
  .CARRIER_TICK, .MOD_REQ, .SUPPLY_LEVEL, .AMPLITUDE,
  .EDGE_ACTIVE, .AT_RESIDUAL
);
`default_nettype wire

// *** dv/tbes_tb_top.sv ***
// Self-checking bench for the edge shaping block: registers and edges.
// Assumes the block stands alone; carrier ticks come every fourth MCLK.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  num_errors++; $display("MISMATCH %s exp %0h seen %0h", nm, exp, got); \
  end end
module tbes_tb_top import tbes_pkg::*;;
  logic              MCLK = 1'b0;
  logic              RST_B = 1'b0;
  logic [ADDR_W-1:0] ADDR = 8'h00;
  logic [DATA_W-1:0] WDATA = 8'h00;
  logic              WR_STB = 1'b0;
  logic              RD_STB = 1'b0;
  logic [DATA_W-1:0] RDATA;
  logic              CARRIER_TICK = 1'b0;
  logic              MOD_REQ = 1'b0;
  logic [7:0]        SUPPLY_LEVEL = 8'h80;
  logic [7:0]        sup_req = 8'h80;
  logic [7:0]        AMPLITUDE;
  logic              EDGE_ACTIVE;
  logic              AT_RESIDUAL;
  logic [1:0]        tdiv = 2'h0;
  logic [7:0]        d;
  logic [7:0]        mask [4] = '{8'h77, 8'h9f, 8'hff, 8'hff};
  logic [7:0]        res [3] = '{8'h00, 8'h9a, 8'hff};
  int                nl [4] = '{0, 1, 5, 31};
  int                num_errors = 0;
  int                compares = 0;
  int                ticks = 0;
  int                i;
  int                s;
  int                c;

  always #5 MCLK = ~MCLK;

  // Ticks are counted only while an edge runs, giving the edge length.
  always @(posedge MCLK) begin
    tdiv <= tdiv + 2'h1;
    CARRIER_TICK <= (tdiv == 2'h3);
    if (CARRIER_TICK === 1'b1 && EDGE_ACTIVE === 1'b1) ticks++;
  end

  tbes_top i_tbes_top (
    .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .CARRIER_TICK(CARRIER_TICK), .MOD_REQ(MOD_REQ),
    .SUPPLY_LEVEL(SUPPLY_LEVEL), .AMPLITUDE(AMPLITUDE),
    .EDGE_ACTIVE(EDGE_ACTIVE), .AT_RESIDUAL(AT_RESIDUAL)
  );

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= v;
    WR_STB <= 1'b1;
    @(posedge MCLK);
    WR_STB <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge MCLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge MCLK);
    RD_STB <= 1'b0;
    #1 v = RDATA;
  endtask : rd

  // Six cycles cover the first tick, so a running edge is seen by then.
  task automatic do_edge(input logic m, input int nt);
    int n;
    ticks = 0;
    // A tick must copy freshly written settings before the request moves.
    repeat (5) @(posedge MCLK);
    SUPPLY_LEVEL <= sup_req;
    MOD_REQ <= m;
    repeat (6) @(posedge MCLK);
    n = 0;
    while (EDGE_ACTIVE === 1'b1 && n < 400) begin
      @(posedge MCLK);
      n++;
    end
    if (n >= 400) num_errors++;
    // With a count of zero the amplitude lands one tick late; wait past it.
    repeat (6) @(posedge MCLK);
    #1;
    if (nt >= 0) `CHK("ticks", nt, ticks)
    `CHK("at_res", m, AT_RESIDUAL)
  endtask : do_edge

  task stop_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // -----------------------------------------------------------------
  // Tests
  // -----------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge MCLK);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge MCLK);
    RST_B <= 1'b1;
    #1 `CHK("amp_rst", 8'hff, AMPLITUDE)
    for (i = 0; i < 4; i++) begin
      rd({CFG_IDX[i][5:0], 2'h0}, d);
      `CHK("cfg_rst", 8'h00, d)
    end
    for (i = 0; i < 4; i++) wr({CFG_IDX[i][5:0], 2'h0}, 8'hff);
    for (i = 0; i < 4; i++) begin
      rd({CFG_IDX[i][5:0], 2'h0}, d);
      `CHK("cfg_mask", mask[i], d)
    end
    wr(8'h10, 8'h5a);
    rd(8'h10, d);
    `CHK("unmapped", 8'h00, d)
    wr(8'h98, 8'h00);
    wr(8'ha0, 8'h40);
    wr(8'ha4, 8'h11);
    for (s = 0; s < 2; s++) begin
      for (i = 0; i < 4; i++) begin
        wr(8'h9c, {s[0], 2'h0, nl[i][4:0]});
        do_edge(1'b1, nl[i] * (s + 1));
        `CHK("fall_end", 8'h40, AMPLITUDE)
        do_edge(1'b0, nl[i] * (s + 1));
        `CHK("rise_end", 8'hff, AMPLITUDE)
      end
    end
    wr(8'h9c, 8'h04);
    for (i = 0; i < 3; i++) begin
      wr(8'ha0, res[i]);
      do_edge(1'b1, 4);
      `CHK("residual", res[i], AMPLITUDE)
      do_edge(1'b0, 4);
    end
    wr(8'ha0, 8'h40);
    wr(8'h98, 8'h35);
    for (c = 1; c < 7; c++) begin
      wr(8'ha4, {c[3:0], c[3:0]});
      do_edge(1'b1, 4);
      `CHK("code_fall", 8'h40, AMPLITUDE)
      do_edge(1'b0, 4);
      `CHK("code_rise", 8'hff, AMPLITUDE)
    end
    // A low supply moves only the adapted codes away from the residual.
    for (c = 4; c < 7; c++) begin
      wr(8'ha4, {c[3:0], c[3:0]});
      // The supply drops with the request, so full carrier never sags first.
      sup_req = 8'h60;
      do_edge(1'b1, 4);
      sup_req = 8'h80;
      `CHK("supply", c == 4, AMPLITUDE == 8'h40)
      @(posedge MCLK);
      SUPPLY_LEVEL <= 8'h80;
      repeat (8) @(posedge MCLK);
      do_edge(1'b0, 4);
      `CHK("supply_rise", 8'hff, AMPLITUDE)
    end
    wr(8'ha4, 8'h10);
    do_edge(1'b1, 4);
    rd(8'hc0, d);
    `CHK("st_fall", 8'h20, d & 8'he0)
    do_edge(1'b0, -1);
    rd(8'hc0, d);
    `CHK("st_rise", 8'h40, d & 8'he0)
    wr(8'hc0, 8'h40);
    rd(8'hc0, d);
    `CHK("st_clear", 8'h00, d & 8'he0)
    stop_test();
  end
endmodule : tbes_tb_top
`default_nettype wire
